// ### trace_pkg.sv
// shared constants and types for the section trace message processor
package trace_pkg;

   // register offsets
   localparam logic [7:0] TRACE_CONTROL_OFS = 8'h20;
   localparam logic [7:0] TRACE_STATUS_OFS = 8'h21;
   localparam logic [7:0] INDIRECT_ADDR_OFS = 8'h22;
   localparam logic [7:0] INDIRECT_DATA_OFS = 8'h23;

   // reset values
   localparam logic [7:0] TRACE_CONTROL_RST = 8'h04;
   localparam logic [7:0] INDIRECT_ADDR_RST = 8'h00;
   localparam logic [7:0] INDIRECT_DATA_RST = 8'h00;

   // status register field positions
   localparam int STAT_BUSY_POS = 7;
   localparam int STAT_UNS_EVT_POS = 3;
   localparam int STAT_UNS_POS = 2;
   localparam int STAT_MIS_EVT_POS = 1;
   localparam int STAT_MIS_POS = 0;

   // indirect address field positions
   localparam int IND_READ_POS = 7;
   localparam int IND_PAGE_POS = 6;

   // message lengths, as last index in the buffer
   localparam logic [5:0] LAST_IDX_SHORT = 6'h0F;
   localparam logic [5:0] LAST_IDX_LONG = 6'h3F;
   localparam int BUF_DEPTH = 64;

   // alignment characters for long messages
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;

   // persistence and instability counts
   localparam logic [2:0] PERSIST_FIVE = 3'h5;
   localparam logic [2:0] PERSIST_THREE = 3'h3;
   localparam logic [3:0] UNSTABLE_COUNT = 4'h8;

   // trace control register layout
   typedef struct packed {
      logic unused;
      logic rx_buffer_select;
      logic trace_unstable_irq_en;
      logic trace_mismatch_irq_en;
      logic persistence_five_sel;
      logic tx_trace_null;
      logic trace_align_disable;
      logic msg_length_short_sel;
   } ctrl_type;

   // indirect access request held while busy
   typedef struct packed {
      logic indirect_read_sel;
      logic page_high;
      logic [5:0] index;
   } ind_addr_type;

endpackage : trace_pkg

// ### section_trace_message_processor.sv
// section trace capture, persistence, mismatch check and transmit source
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module section_trace_message_processor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // received trace bytes
   input wire logic [7:0] i_rx_byte,
   input wire logic i_rx_valid,
   // transmit overhead inserter
   input wire logic i_tx_req,
   output logic [7:0] o_tx_byte,
   output logic o_tx_valid,
   // interrupt, active low
   output logic o_irq_out_n
);

   // buffers
   logic [7:0] cap_mem [0:trace_pkg::BUF_DEPTH-1];
   logic [7:0] exp_mem [0:trace_pkg::BUF_DEPTH-1];
   logic [7:0] tx_mem [0:trace_pkg::BUF_DEPTH-1];

   // registers
   trace_pkg::ctrl_type ctrl_q;
   trace_pkg::ind_addr_type ind_addr_q;
   logic [7:0] ind_data_q;
   logic busy_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic irq_n_q;

   // receive state
   logic [5:0] wp_q;
   logic [7:0] prev1_q;
   logic [7:0] prev2_q;
   logic diff_q;
   logic mis_acc_q;
   logic [2:0] same_cnt_q;
   logic [3:0] diff_cnt_q;
   logic unstable_q;
   logic mismatch_q;
   logic mis_evt_q;
   logic uns_evt_q;

   // transmit state
   logic [5:0] tx_ptr_q;
   logic [7:0] tx_byte_q;
   logic tx_valid_q;

   // decoded strobes and receive helpers
   logic wr_ctrl;
   logic wr_addr;
   logic wr_data;
   logic rd_stat;
   logic [5:0] last_idx;
   logic align_start;
   logic [5:0] rx_idx;
   logic msg_end;
   logic acc_diff;
   logic acc_mis;
   logic [2:0] need_cnt;
   logic accept;
   logic go_unstable;
   logic mis_set;
   logic uns_set;
   logic [7:0] status_val;
   logic ind_wr_exp;
   logic ind_wr_tx;
   logic [5:0] tx_idx;

   // register decode
   assign wr_ctrl = i_wr && (i_addr == trace_pkg::TRACE_CONTROL_OFS);
   assign wr_addr = i_wr && (i_addr == trace_pkg::INDIRECT_ADDR_OFS);
   assign wr_data = i_wr && (i_addr == trace_pkg::INDIRECT_DATA_OFS);
   assign rd_stat = i_rd && (i_addr == trace_pkg::TRACE_STATUS_OFS);

   // message length, high length bit picks the short message
   assign last_idx = ctrl_q.msg_length_short_sel ?
                     trace_pkg::LAST_IDX_SHORT : trace_pkg::LAST_IDX_LONG;

   // alignment start detection
   always_comb begin
      if (ctrl_q.trace_align_disable) begin
         align_start = 1'b0;
      end else if (ctrl_q.msg_length_short_sel) begin
         align_start = i_rx_byte[7];
      end else begin
         align_start = (prev2_q == trace_pkg::CHAR_CR) &&
                       (prev1_q == trace_pkg::CHAR_LF);
      end
   end

   // capture index, a pointer left past a shortened message restarts at 0
   assign rx_idx = (align_start || (wp_q > last_idx)) ? 6'h00 : wp_q;
   assign msg_end = i_rx_valid && (rx_idx == last_idx);

   // per message comparison with previous and expected
   assign acc_diff = ((rx_idx != 6'h00) && diff_q) ||
                     (i_rx_byte != cap_mem[rx_idx]);
   assign acc_mis = ((rx_idx != 6'h00) && mis_acc_q) ||
                    (i_rx_byte != exp_mem[rx_idx]);

   // persistence decisions at message end
   assign need_cnt = ctrl_q.persistence_five_sel ?
                     trace_pkg::PERSIST_FIVE : trace_pkg::PERSIST_THREE;
   assign accept = msg_end && !acc_diff &&
                   ((same_cnt_q + 3'h1) >= need_cnt);
   assign go_unstable = msg_end && acc_diff &&
                        ((diff_cnt_q + 4'h1) >= trace_pkg::UNSTABLE_COUNT);
   assign mis_set = accept && (acc_mis != mismatch_q);
   assign uns_set = (accept && unstable_q) ||
                    (go_unstable && !unstable_q);

   // indirect write targets
   // the capture page has no write path, software only reads it
   assign ind_wr_exp = busy_q && !ind_addr_q.indirect_read_sel &&
                       ctrl_q.rx_buffer_select && ind_addr_q.page_high;
   assign ind_wr_tx = busy_q && !ind_addr_q.indirect_read_sel &&
                      !ctrl_q.rx_buffer_select && !ind_addr_q.page_high;

   // status word
   always_comb begin
      status_val = 8'h00;
      status_val[trace_pkg::STAT_BUSY_POS] = busy_q;
      status_val[trace_pkg::STAT_UNS_EVT_POS] = uns_evt_q;
      status_val[trace_pkg::STAT_UNS_POS] = unstable_q;
      status_val[trace_pkg::STAT_MIS_EVT_POS] = mis_evt_q;
      status_val[trace_pkg::STAT_MIS_POS] = mismatch_q;
   end

   // control register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= trace_pkg::ctrl_type'(trace_pkg::TRACE_CONTROL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= trace_pkg::ctrl_type'(i_wdata);
         ctrl_q.unused <= 1'b0;
      end
   end

   // indirect address register and busy flag
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ind_addr_q <= trace_pkg::ind_addr_type'(trace_pkg::INDIRECT_ADDR_RST);
         busy_q <= 1'b0;
      end else if (wr_addr) begin
         ind_addr_q <= trace_pkg::ind_addr_type'(i_wdata);
         busy_q <= 1'b1;
      end else begin
         busy_q <= 1'b0;
      end
   end

   // indirect data register, loaded by software or by a read access
   // a read access takes priority over a load by software
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ind_data_q <= trace_pkg::INDIRECT_DATA_RST;
      end else if (busy_q && ind_addr_q.indirect_read_sel) begin
         if (!ctrl_q.rx_buffer_select) begin
            ind_data_q <= ind_addr_q.page_high ? 8'h00 :
                          tx_mem[ind_addr_q.index];
         end else if (ind_addr_q.page_high) begin
            ind_data_q <= exp_mem[ind_addr_q.index];
         end else begin
            ind_data_q <= cap_mem[ind_addr_q.index];
         end
      end else if (wr_data) begin
         ind_data_q <= i_wdata;
      end
   end

   // expected message buffer, written by software only
   always_ff @(posedge i_clk) begin
      if (ind_wr_exp) begin
         exp_mem[ind_addr_q.index] <= ind_data_q;
      end
   end

   // transmit message buffer, written by software only
   always_ff @(posedge i_clk) begin
      if (ind_wr_tx) begin
         tx_mem[ind_addr_q.index] <= ind_data_q;
      end
   end

   // capture buffer, written by the receive side only
   always_ff @(posedge i_clk) begin
      if (i_rx_valid) begin
         cap_mem[rx_idx] <= i_rx_byte;
      end
   end

   // capture pointer and alignment history
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wp_q <= 6'h00;
         prev1_q <= 8'h00;
         prev2_q <= 8'h00;
      end else if (i_rx_valid) begin
         wp_q <= (rx_idx >= last_idx) ? 6'h00 : rx_idx + 6'h01;
         prev1_q <= i_rx_byte;
         prev2_q <= prev1_q;
      end
   end

   // running differences within the current message
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         diff_q <= 1'b0;
         mis_acc_q <= 1'b0;
      end else if (i_rx_valid) begin
         diff_q <= acc_diff;
         mis_acc_q <= acc_mis;
      end
   end

   // persistence and instability counters
   // both counts saturate, so a long run never wraps
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         same_cnt_q <= 3'h1;
         diff_cnt_q <= 4'h0;
      end else if (msg_end) begin
         if (acc_diff) begin
            same_cnt_q <= 3'h1;
            if (diff_cnt_q < trace_pkg::UNSTABLE_COUNT) begin
               diff_cnt_q <= diff_cnt_q + 4'h1;
            end
         end else begin
            diff_cnt_q <= 4'h0;
            if (same_cnt_q < trace_pkg::PERSIST_FIVE) begin
               same_cnt_q <= same_cnt_q + 3'h1;
            end
         end
      end
   end

   // stable/unstable and match/mismatch states
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         unstable_q <= 1'b0;
         mismatch_q <= 1'b0;
      end else if (accept) begin
         unstable_q <= 1'b0;
         mismatch_q <= acc_mis;
      end else if (go_unstable) begin
         unstable_q <= 1'b1;
      end
   end

   // sticky events, a new event beats the clear by read
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mis_evt_q <= 1'b0;
         uns_evt_q <= 1'b0;
      end else begin
         mis_evt_q <= mis_set || (mis_evt_q && !rd_stat);
         uns_evt_q <= uns_set || (uns_evt_q && !rd_stat);
      end
   end

   // interrupt output, enables act as the mask
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= !((mis_evt_q && ctrl_q.trace_mismatch_irq_en) ||
                      (uns_evt_q && ctrl_q.trace_unstable_irq_en));
      end
   end

   // read data mux, unmapped reads return zero
   always_comb begin
      rdata_d = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            trace_pkg::TRACE_CONTROL_OFS: rdata_d = ctrl_q;
            trace_pkg::TRACE_STATUS_OFS: rdata_d = status_val;
            trace_pkg::INDIRECT_ADDR_OFS: rdata_d = ind_addr_q;
            trace_pkg::INDIRECT_DATA_OFS: rdata_d = ind_data_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // read data register, valid only the cycle after the read
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // transmit index, folded back when the length shrinks mid-message
   assign tx_idx = (tx_ptr_q > last_idx) ? 6'h00 : tx_ptr_q;

   // transmit byte source
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tx_ptr_q <= 6'h00;
         tx_byte_q <= 8'h00;
         tx_valid_q <= 1'b0;
      end else begin
         tx_valid_q <= i_tx_req;
         if (i_tx_req) begin
            tx_byte_q <= ctrl_q.tx_trace_null ? 8'h00 : tx_mem[tx_idx];
            tx_ptr_q <= (tx_idx >= last_idx) ? 6'h00 : tx_idx + 6'h01;
         end
      end
   end

   // outputs
   assign o_rdata = rdata_q;
   assign o_tx_byte = tx_byte_q;
   assign o_tx_valid = tx_valid_q;
   assign o_irq_out_n = irq_n_q;

endmodule : section_trace_message_processor

// ### trace_checker_sva.sv
// concurrent checks on the trace processor ports, bound to the design
`timescale 1ns/10ps
module trace_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // trace streams and interrupt
   input wire logic [7:0] i_rx_byte,
   input wire logic i_rx_valid,
   input wire logic i_tx_req,
   input wire logic [7:0] o_tx_byte,
   input wire logic o_tx_valid,
   input wire logic o_irq_out_n
);
   logic [7:0] ctrl_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // shadow copy of the control register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= trace_pkg::TRACE_CONTROL_RST;
      end else if (i_wr && i_addr == trace_pkg::TRACE_CONTROL_OFS) begin
         ctrl_q <= i_wdata;
      end
   end
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_ctrl_read: assert property (i_rd && i_addr == 8'h20 |=>
      o_rdata == {1'b0, ctrl_q[6:0]}) else $error("control readback wrong");
   a_unmapped_zero: assert property (i_rd && (i_addr < 8'h20 ||
      i_addr > 8'h23) |=> o_rdata == 8'h00) else $error("unmapped read");
   a_busy_high: assert property (i_wr && i_addr == 8'h22 ##1
      i_rd && i_addr == 8'h21 |=> o_rdata[7]) else $error("busy not set");
   a_busy_low: assert property (i_wr && i_addr == 8'h22 ##3
      i_rd && i_addr == 8'h21 |=> !o_rdata[7]) else $error("busy stuck");
   a_txv_pulse: assert property (i_tx_req |=> o_tx_valid)
      else $error("transmit byte not answered");
   a_txv_cause: assert property (o_tx_valid |-> $past(i_tx_req))
      else $error("transmit valid without request");
   a_tx_null: assert property (i_tx_req && ctrl_q[2] |=>
      o_tx_byte == 8'h00) else $error("null message not zero");
   a_irq_mask: assert property (ctrl_q[5:4] == 2'h0 |=> o_irq_out_n)
      else $error("interrupt with both enables low");
endmodule : trace_checker

bind section_trace_message_processor trace_checker chk_i (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_byte(i_rx_byte),
   .i_rx_valid(i_rx_valid), .i_tx_req(i_tx_req), .o_tx_byte(o_tx_byte),
   .o_tx_valid(o_tx_valid), .o_irq_out_n(o_irq_out_n));

// ### trace_tx_sink.sv
// model of the transmit overhead inserter pulling trace bytes
`timescale 1ns/10ps
module trace_tx_sink (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // trace byte from the block
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte,
   // request and last byte taken
   output logic o_tx_req,
   output logic [7:0] o_seen
);
   logic [1:0] cnt_q;
   // one request every four cycles, keep each answered byte
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_q <= 2'h0;
         o_tx_req <= 1'b0;
         o_seen <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         o_tx_req <= (cnt_q == 2'h3);
         if (i_tx_valid) o_seen <= i_tx_byte;
      end
   end
endmodule : trace_tx_sink

// ### test_section_trace_message_processor.sv
// self-checking bench for the section trace message processor
`timescale 1ns/10ps
module test_section_trace_message_processor;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_rx_byte = 8'h00;
   logic i_rx_valid = 1'b0;
   logic tx_req, tx_valid, irq_n;
   logic [7:0] rdata, tx_byte, seen, v;
   int err_count = 0;
   int cmp_count = 0;
   // free running clock
   always #4 i_clk = ~i_clk;
   section_trace_message_processor dut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .i_rx_byte(i_rx_byte), .i_rx_valid(i_rx_valid),
      .i_tx_req(tx_req), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
      .o_irq_out_n(irq_n));
   trace_tx_sink sink (.i_clk(i_clk), .i_nrst(i_nrst), .i_tx_valid(tx_valid),
      .i_tx_byte(tx_byte), .o_tx_req(tx_req), .o_seen(seen));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      if (i_wr) @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rc(input logic [7:0] a, input logic [7:0] e);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      v = rdata;
      @(posedge i_clk);
      if (a == 8'h21 && e[7]) chk("busy", 8'h80, v & 8'h80);
      else if (a != 8'h23) chk("rdata", e, v);
   endtask : rc
   task poll;
      rc(8'h21, 8'h80);
      i_rd <= 1'b1;
      i_addr <= 8'h21;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk("busy", 8'h00, rdata & 8'h80);
      @(posedge i_clk);
   endtask : poll
   task iw(input logic [6:0] x, input logic [7:0] d);
      wr(8'h23, d);
      wr(8'h22, {1'b0, x});
      poll();
   endtask : iw
   task ir(input logic [6:0] x, input logic [7:0] e);
      wr(8'h22, {1'b1, x});
      poll();
      rc(8'h23, e);
      chk("indirect", e, v);
   endtask : ir
   task irq(input logic e);
      @(negedge i_clk);
      chk("irq", {7'h00, e}, {7'h00, irq_n});
      @(posedge i_clk);
   endtask : irq
   task rxb(input logic [7:0] b);
      i_rx_valid <= 1'b1;
      i_rx_byte <= b;
      @(posedge i_clk);
   endtask : rxb
   function automatic logic [7:0] mb(input int i, input logic [7:0] b5);
      return (i == 0) ? 8'h80 : (i == 5) ? b5 : 8'h30 + 8'(i);
   endfunction : mb
   task msg(input logic [7:0] b5);
      for (int i = 0; i < 16; i++) rxb(mb(i, b5));
      i_rx_valid <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask : msg
   task t_reset;
      rc(8'h20, 8'h04);
      rc(8'h21, 8'h00);
      rc(8'h22, 8'h00);
      rc(8'h30, 8'h00);
      $display("reset values test done");
   endtask : t_reset
   task t_tx;
      logic [7:0] s0;
      for (int i = 0; i < 16; i++) iw(7'(i), 8'h40 + 8'(i));
      chk("tx byte", 8'h00, seen);
      wr(8'h20, 8'h01);
      repeat (9) @(negedge i_clk);
      s0 = seen;
      for (int k = 1; k < 7; k++) begin
         repeat (4) @(negedge i_clk);
         chk("tx byte", {4'h4, s0[3:0] + 4'(k)}, seen);
      end
      @(posedge i_clk);
      ir(7'h03, 8'h43);
      ir(7'h40, 8'h00);
      $display("transmit test done");
   endtask : t_tx
   task t_rx;
      wr(8'h20, 8'h71);
      for (int i = 0; i < 16; i++) iw(7'(64 + i), mb(i, 8'h59));
      repeat (3) rxb(8'h11);
      msg(8'h35);
      msg(8'h35);
      rc(8'h21, 8'h00);
      msg(8'h35);
      irq(1'b0);
      rc(8'h21, 8'h03);
      irq(1'b1);
      rc(8'h21, 8'h01);
      wr(8'h20, 8'h69);
      repeat (4) msg(8'h59);
      rc(8'h21, 8'h01);
      msg(8'h59);
      irq(1'b1);
      rc(8'h21, 8'h02);
      for (int k = 0; k < 8; k++) begin
         msg(8'h50 + 8'(k));
         if (k == 6) rc(8'h21, 8'h00);
      end
      irq(1'b0);
      rc(8'h21, 8'h0C);
      ir(7'h00, 8'h80);
      $display("receive test done");
   endtask : t_rx
   task t_align;
      wr(8'h20, 8'h70);
      rxb(8'h0D);
      rxb(8'h0A);
      rxb(8'h55);
      i_rx_valid <= 1'b0;
      ir(7'h00, 8'h55);
      wr(8'h20, 8'h72);
      rxb(8'h0D);
      rxb(8'h0A);
      rxb(8'h66);
      i_rx_valid <= 1'b0;
      ir(7'h03, 8'h66);
      ir(7'h00, 8'h55);
      $display("alignment test done");
   endtask : t_align
   task test_done;
      $display("checks %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   // main sequence
   initial begin
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_align();
      test_done();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      test_done();
   end
endmodule : test_section_trace_message_processor
